// [pcs_pkg.sv]
/*
  Constants, field layouts and carrier types for the pad pull-up and
  clock-out select block. Assumes a 32-bit AHB-Lite register bus and a
  single 20 MHz system clock.
*/
// Functional notes
// - Set group bit disables that group's pull-ups
// - Reserved bits read zero, ignore writes
// - Bit 14 fault A3, bit 7 A0-A2
// - Bit 13 CAN receive, bit 12 boot-mode
// - Bit 11 reset pin, bit 10 both interrupts
// - Bit 8 all four fault B inputs
// - Bit 5 bus strobes, bit 3 JTAG pins
// - Bits 4..0 pick clock-out source, default zero
// - Codes 7,8,16,17: osc, PLL, converters A/B
// - Tristate bit 5 floats the clock-out pin
// - Port enable first, then address/clock choice
// - Port B 7..4 default to address 23..20
// - Bit 9: address 23 or master oscillator
// - Bit 8: address 22 or secondary clock
// - Bit 7: address 21 or system clock
// - Bit 6: address 20 or prescaler reference
package pcs_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0]  PULLUP_DISABLE_IDX   = 8'h08;
  localparam logic [7:0]  CLOCK_OUT_SELECT_IDX = 8'h0A;
  localparam logic [9:0]  PULLUP_DISABLE_ADDR   = {PULLUP_DISABLE_IDX, 2'b00};
  localparam logic [9:0]  CLOCK_OUT_SELECT_ADDR = {CLOCK_OUT_SELECT_IDX, 2'b00};

  // Implemented bits and values after reset
  localparam logic [15:0] PULLUP_DISABLE_MASK    = 16'h7FA8;
  localparam logic [15:0] CLOCK_OUT_SELECT_MASK  = 16'h03FF;
  localparam logic [15:0] PULLUP_DISABLE_RESET   = 16'h0000;
  localparam logic [15:0] CLOCK_OUT_SELECT_RESET = 16'h0000;

  // Field positions
  localparam int FAULT_A_HIGH_BIT  = 14;
  localparam int CAN_RX_BIT        = 13;
  localparam int BOOT_MODE_BIT     = 12;
  localparam int RESET_PIN_BIT     = 11;
  localparam int INTERRUPT_BIT     = 10;
  localparam int BOOT_SELECT_BIT   = 9;
  localparam int FAULT_B_BIT       = 8;
  localparam int FAULT_A_LOW_BIT   = 7;
  localparam int STROBE_BIT        = 5;
  localparam int JTAG_BIT          = 3;
  localparam int ALT_LSB           = 6;
  localparam int ALT_MSB           = 9;
  localparam int TRISTATE_BIT      = 5;
  localparam int SOURCE_MSB        = 4;

  // Clock-out source codes
  localparam logic [4:0] SRC_SYSTEM      = 5'h00;
  localparam logic [4:0] SRC_OSCILLATOR  = 5'h07;
  localparam logic [4:0] SRC_PLL         = 5'h08;
  localparam logic [4:0] SRC_CONVERTER_A = 5'h10;
  localparam logic [4:0] SRC_CONVERTER_B = 5'h11;

  // AHB transfer types
  localparam logic [1:0] HTRANS_IDLE   = 2'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef struct packed {
    logic faultAHighPullupDisable;
    logic canRxPullupDisable;
    logic extBusBootModePullupDisable;
    logic resetPinPullupDisable;
    logic interruptPinsPullupDisable;
    logic bootSelectPullupDisable;
    logic faultBGroupPullupDisable;
    logic faultALowPullupDisable;
    logic strobePullupDisable;
    logic jtagPullupDisable;
  } pcs_pullup_t;

  typedef struct packed {
    logic masterOscillatorClock;
    logic secondarySystemClock;
    logic systemClock;
    logic prescalerReferenceClock;
    logic oscillatorOutput;
    logic pllOutputClock;
    logic converterAClock;
    logic converterBClock;
  } pcs_clocks_t;

endpackage : pcs_pkg

// [pcs_pad_ctrl.sv]
/*
  Pad pull-up disable and clock-out select registers as an AHB-Lite slave.
  Assumes a single master, word transfers only, and that pad cells and the
  GPIO port B enables live outside this block.
*/
`timescale 1ns/1ps
module pcs_pad_ctrl
  import pcs_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // Pull-up controls toward the pads
  output pcs_pullup_t      pullups,
  // Clock sources and clock-out pin
  input  wire pcs_clocks_t clocks,
  input  wire logic [15:0] factoryTestClocks,
  output logic             clockOutPin,
  output logic             clockOutPinOe,
  // Port B upper nibble
  input  wire logic [3:0]  portBPeripheralEnable,
  input  wire logic [3:0]  extAddrHigh,
  output logic [3:0]       portBPeripheralOut
);

  // Address phase capture
  logic        dataPhaseWrite_q;
  logic        dataPhaseWrite_d;
  logic [9:0]  dataPhaseAddr_q;
  logic [9:0]  dataPhaseAddr_d;
  logic [31:0] hrdata_q;
  logic [31:0] hrdata_d;

  // Registers
  logic [15:0] pullupDisable_q;
  logic [15:0] pullupDisable_d;
  logic [15:0] clockOutSelect_q;
  logic [15:0] clockOutSelect_d;

  // Decode
  wire         addrPhase;
  wire         addrPhaseRead;
  wire         writePullup;
  wire         writeClockOut;
  wire         readPullup;
  wire         readClockOut;
  wire [9:0]   reqAddr;
  wire [31:0]  sourceVector;
  wire [4:0]   sourceSelect;
  wire         clockTristate;
  wire [3:0]   altSelect;
  wire [3:0]   altClocks;
  wire [3:0]   portBMux;

  assign reqAddr       = haddr[9:0];
  assign addrPhase     = hsel & hready & (htrans == HTRANS_NONSEQ);
  assign addrPhaseRead = addrPhase & ~hwrite;
  // Full word only; sizes other than word are ignored as writes
  assign dataPhaseWrite_d = addrPhase & hwrite & (hsize == 3'h2);
  assign dataPhaseAddr_d  = addrPhase ? reqAddr : dataPhaseAddr_q;

  assign writePullup   = dataPhaseWrite_q & (dataPhaseAddr_q == PULLUP_DISABLE_ADDR);
  assign writeClockOut = dataPhaseWrite_q & (dataPhaseAddr_q == CLOCK_OUT_SELECT_ADDR);
  assign readPullup    = addrPhaseRead & (reqAddr == PULLUP_DISABLE_ADDR);
  assign readClockOut  = addrPhaseRead & (reqAddr == CLOCK_OUT_SELECT_ADDR);

  // Reserved bits never store anything
  assign pullupDisable_d  = writePullup ?
                            (hwdata[15:0] & PULLUP_DISABLE_MASK) :
                            pullupDisable_q;
  assign clockOutSelect_d = writeClockOut ?
                            (hwdata[15:0] & CLOCK_OUT_SELECT_MASK) :
                            clockOutSelect_q;

  // Read data uses next values so a read right after a write sees it
  assign hrdata_d = readPullup   ? {16'h0000, pullupDisable_d}  :
                    readClockOut ? {16'h0000, clockOutSelect_d} :
                    addrPhaseRead ? 32'h0000_0000 : hrdata_q;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      dataPhaseWrite_q <= 1'b0;
      dataPhaseAddr_q  <= 10'h000;
      hrdata_q         <= 32'h0000_0000;
    end else begin
      dataPhaseWrite_q <= dataPhaseWrite_d;
      dataPhaseAddr_q  <= dataPhaseAddr_d;
      hrdata_q         <= hrdata_d;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pullupDisable_q  <= PULLUP_DISABLE_RESET;
      clockOutSelect_q <= CLOCK_OUT_SELECT_RESET;
    end else begin
      pullupDisable_q  <= pullupDisable_d;
      clockOutSelect_q <= clockOutSelect_d;
    end
  end

  // Zero-wait slave, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;

  // Pull-up groups: a 1 turns the group's pull-ups off
  assign pullups.faultAHighPullupDisable     = pullupDisable_q[FAULT_A_HIGH_BIT];
  assign pullups.faultALowPullupDisable      = pullupDisable_q[FAULT_A_LOW_BIT];
  assign pullups.canRxPullupDisable          = pullupDisable_q[CAN_RX_BIT];
  assign pullups.extBusBootModePullupDisable = pullupDisable_q[BOOT_MODE_BIT];
  assign pullups.resetPinPullupDisable       = pullupDisable_q[RESET_PIN_BIT];
  assign pullups.interruptPinsPullupDisable  = pullupDisable_q[INTERRUPT_BIT];
  // Boot select pin is grounded in the package; software should set this
  assign pullups.bootSelectPullupDisable     = pullupDisable_q[BOOT_SELECT_BIT];
  assign pullups.faultBGroupPullupDisable    = pullupDisable_q[FAULT_B_BIT];
  assign pullups.strobePullupDisable         = pullupDisable_q[STROBE_BIT];
  assign pullups.jtagPullupDisable           = pullupDisable_q[JTAG_BIT];

  // Clock-out mux; test codes pass factory clocks, unused codes give 0
  assign sourceVector[0]     = clocks.systemClock;
  assign sourceVector[6:1]   = factoryTestClocks[6:1];
  assign sourceVector[7]     = clocks.oscillatorOutput;
  assign sourceVector[8]     = clocks.pllOutputClock;
  assign sourceVector[15:9]  = factoryTestClocks[15:9];
  assign sourceVector[16]    = clocks.converterAClock;
  assign sourceVector[17]    = clocks.converterBClock;
  assign sourceVector[31:18] = 14'h0000;

  assign sourceSelect  = clockOutSelect_q[SOURCE_MSB:0];
  assign clockTristate = clockOutSelect_q[TRISTATE_BIT];
  // Clocks are routed, not retimed: a flop here would halve the rate
  assign clockOutPin   = sourceVector[sourceSelect];
  assign clockOutPinOe = ~clockTristate;

  // Port B 7..4: enable gates, then address or clock per bit
  assign altSelect = clockOutSelect_q[ALT_MSB:ALT_LSB];
  assign altClocks = {clocks.masterOscillatorClock,
                      clocks.secondarySystemClock,
                      clocks.systemClock,
                      clocks.prescalerReferenceClock};
  assign portBMux  = (altSelect & altClocks) | (~altSelect & extAddrHigh);
  assign portBPeripheralOut = portBPeripheralEnable & portBMux;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence clockOutWrite;
    dataPhaseWrite_q && dataPhaseAddr_q == CLOCK_OUT_SELECT_ADDR;
  endsequence

  sequence clockOutRead;
    addrPhaseRead && reqAddr == CLOCK_OUT_SELECT_ADDR && !writeClockOut;
  endsequence

  sequence pullupWrite;
    dataPhaseWrite_q && dataPhaseAddr_q == PULLUP_DISABLE_ADDR;
  endsequence

  sequence pullupRead;
    addrPhaseRead && reqAddr == PULLUP_DISABLE_ADDR && !writePullup;
  endsequence

  reserved_zero_a: assert property (
    pullupRead |=> (hrdata[15:0] & ~PULLUP_DISABLE_MASK) == 16'h0000
                   && hrdata[31:16] == 16'h0000)
    else $error("reserved pull-up bits read nonzero");

  readback_word_a: assert property (
    pullupWrite |=> pullupDisable_q == ($past(hwdata[15:0]) & PULLUP_DISABLE_MASK))
    else $error("pull-up register did not take written value");

  fault_group_a: assert property (
    pullupWrite |=> pullups.faultAHighPullupDisable == $past(hwdata[FAULT_A_HIGH_BIT])
                    && pullups.faultALowPullupDisable == $past(hwdata[FAULT_A_LOW_BIT]))
    else $error("fault A pull-up group wrong after write");

  fault_b_a: assert property (
    pullupWrite ##1 !writePullup [*2] |-> pullups.faultBGroupPullupDisable
                                          == $past(hwdata[FAULT_B_BIT], 2))
    else $error("fault B group pull-up did not hold");

  clock_source_a: assert property (
    clockOutSelect_q[4:0] == SRC_OSCILLATOR |-> clockOutPin == clocks.oscillatorOutput)
    else $error("oscillator not on clock-out pin");

  tristate_pin_a: assert property (
    $rose(clockOutSelect_q[5]) |-> !clockOutPinOe)
    else $error("clock-out pin still driven when tristated");

  alt_b7_a: assert property (
    portBPeripheralEnable[3] && !clockOutSelect_q[9] |->
      portBPeripheralOut[3] == extAddrHigh[3])
    else $error("port B7 not carrying address bit 23");

  alt_b6_a: assert property (
    portBPeripheralEnable[2] && clockOutSelect_q[8] |->
      portBPeripheralOut[2] == clocks.secondarySystemClock)
    else $error("port B6 not carrying secondary clock");

  port_enable_a: assert property (
    portBPeripheralEnable == 4'h0 |-> portBPeripheralOut == 4'h0)
    else $error("port B output active without peripheral enable");

  default_route_a: assert property (
    !writeClockOut [*3] ##0 clockOutSelect_q[9:6] == 4'h0 |=>
      clockOutSelect_q[9:6] == 4'h0)
    else $error("address routing changed without a write");

  zero_wait_a: assert property (
    addrPhase |=> hreadyout && !hresp)
    else $error("slave inserted wait or error");

  // Remaining pull-up groups
  can_boot_a: assert property (
    pullupWrite |=> pullups.canRxPullupDisable == $past(hwdata[CAN_RX_BIT])
                    && pullups.extBusBootModePullupDisable == $past(hwdata[BOOT_MODE_BIT]))
    else $error("CAN receive or boot-mode pull-up wrong after write");

  reset_irq_a: assert property (
    pullupWrite |=> pullups.resetPinPullupDisable == $past(hwdata[RESET_PIN_BIT])
                    && pullups.interruptPinsPullupDisable == $past(hwdata[INTERRUPT_BIT]))
    else $error("reset or interrupt pull-up wrong after write");

  strobe_jtag_a: assert property (
    pullupWrite |=> pullups.strobePullupDisable == $past(hwdata[STROBE_BIT])
                    && pullups.jtagPullupDisable == $past(hwdata[JTAG_BIT]))
    else $error("strobe or JTAG pull-up wrong after write");

  boot_select_a: assert property (
    pullupWrite |=> pullups.bootSelectPullupDisable == $past(hwdata[BOOT_SELECT_BIT]))
    else $error("boot select pull-up wrong after write");

  pullup_hold_a: assert property (
    !writePullup |=> $stable(pullupDisable_q))
    else $error("pull-up register changed without a write");

  pullup_read_a: assert property (
    pullupRead |=> hrdata[15:0] == $past(pullupDisable_q))
    else $error("pull-up read data differs from register");

  // Clock-out select register
  clock_readback_a: assert property (
    clockOutWrite |=> clockOutSelect_q == ($past(hwdata[15:0]) & CLOCK_OUT_SELECT_MASK))
    else $error("clock-out register did not take written value");

  clock_reserved_a: assert property (
    clockOutRead |=> hrdata[31:10] == 22'h000000)
    else $error("reserved clock-out bits read nonzero");

  clock_read_a: assert property (
    clockOutRead |=> hrdata[15:0] == $past(clockOutSelect_q))
    else $error("clock-out read data differs from register");

  clock_hold_a: assert property (
    !writeClockOut |=> $stable(clockOutSelect_q))
    else $error("clock-out register changed without a write");

  // Narrow writes are dropped on purpose: no byte lanes to merge
  narrow_write_a: assert property (
    addrPhase && hwrite && hsize != 3'h2 |=> !dataPhaseWrite_q)
    else $error("narrow write was accepted");

  unmapped_write_a: assert property (
    dataPhaseWrite_q && !writePullup && !writeClockOut |=>
      $stable(pullupDisable_q) && $stable(clockOutSelect_q))
    else $error("unmapped write changed a register");

  read_hold_a: assert property (
    !addrPhaseRead |=> $stable(hrdata))
    else $error("read data moved without a read");

  addr_capture_a: assert property (
    addrPhase |=> dataPhaseAddr_q == $past(reqAddr))
    else $error("data phase address not captured");

  system_clock_a: assert property (
    sourceSelect == SRC_SYSTEM |-> clockOutPin == clocks.systemClock)
    else $error("system clock not on clock-out pin");

  pll_source_a: assert property (
    sourceSelect == SRC_PLL |-> clockOutPin == clocks.pllOutputClock)
    else $error("PLL clock not on clock-out pin");

  converter_a_a: assert property (
    sourceSelect == SRC_CONVERTER_A |-> clockOutPin == clocks.converterAClock)
    else $error("converter A clock not on clock-out pin");

  converter_b_a: assert property (
    sourceSelect == SRC_CONVERTER_B |-> clockOutPin == clocks.converterBClock)
    else $error("converter B clock not on clock-out pin");

  pin_enable_a: assert property (
    clockOutPinOe == !clockOutSelect_q[TRISTATE_BIT])
    else $error("clock-out enable disagrees with tristate bit");

  oe_return_a: assert property (
    $fell(clockOutSelect_q[TRISTATE_BIT]) |-> clockOutPinOe)
    else $error("clock-out pin not driven after tristate cleared");

  // Port B alternate functions
  alt_b7_clock_a: assert property (
    portBPeripheralEnable[3] && clockOutSelect_q[9] |->
      portBPeripheralOut[3] == clocks.masterOscillatorClock)
    else $error("port B7 not carrying master oscillator");

  alt_b6_addr_a: assert property (
    portBPeripheralEnable[2] && !clockOutSelect_q[8] |->
      portBPeripheralOut[2] == extAddrHigh[2])
    else $error("port B6 not carrying address bit 22");

  alt_b5_addr_a: assert property (
    portBPeripheralEnable[1] && !clockOutSelect_q[7] |->
      portBPeripheralOut[1] == extAddrHigh[1])
    else $error("port B5 not carrying address bit 21");

  alt_b5_clock_a: assert property (
    portBPeripheralEnable[1] && clockOutSelect_q[7] |->
      portBPeripheralOut[1] == clocks.systemClock)
    else $error("port B5 not carrying system clock");

  alt_b4_addr_a: assert property (
    portBPeripheralEnable[0] && !clockOutSelect_q[6] |->
      portBPeripheralOut[0] == extAddrHigh[0])
    else $error("port B4 not carrying address bit 20");

  alt_b4_clock_a: assert property (
    portBPeripheralEnable[0] && clockOutSelect_q[6] |->
      portBPeripheralOut[0] == clocks.prescalerReferenceClock)
    else $error("port B4 not carrying prescaler reference");

  port_gate_a: assert property (
    (portBPeripheralOut & ~portBPeripheralEnable) == 4'h0)
    else $error("port B bit active without its peripheral enable");

endmodule : pcs_pad_ctrl

// [pcs_clock_src.sv]
/*
  Board-side clock sources that feed the clock-out and port B muxes.
  Assumes only the pad block and the bench's pin checks use them; edges sit off the bench's sample grid.
*/
`timescale 1ns/1ps
module pcs_clock_src
  import pcs_pkg::*;
(
  // Clock sources toward the pad block
  output pcs_clocks_t clocks,
  output logic [15:0] factoryTestClocks
);
  integer seedSrc = 32'h4ce9;

  // Half-ns offset so no source moves at an instant the bench samples
  initial begin
    clocks            = pcs_clocks_t'(8'h00);
    factoryTestClocks = 16'h0000;
    #0.5;
    forever begin
      #3;
      clocks            = pcs_clocks_t'(8'($random(seedSrc)));
      factoryTestClocks = 16'($random(seedSrc));
    end
  end
endmodule : pcs_clock_src

// [pcs_pad_ctrl_bench.sv]
/*
  Self-checking bench for the pad pull-up and clock-out select block.
  Assumes the bench is the only AHB-Lite master and pcs_clock_src drives clocks.
*/
`timescale 1ns/1ps
module pcs_pad_ctrl_bench
  import pcs_pkg::*;
;
  localparam logic [31:0] PUD = 32'(PULLUP_DISABLE_ADDR);
  localparam logic [31:0] COS = 32'(CLOCK_OUT_SELECT_ADDR);
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = HTRANS_IDLE;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [2:0]  sz = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic        hreadyout;
  logic        hresp;
  logic        clockOutPin;
  logic        clockOutPinOe;
  logic [31:0] hrdata;
  pcs_pullup_t pullups;
  pcs_clocks_t clocks;
  logic [15:0] factoryTestClocks;
  logic [3:0]  portBPeripheralEnable = 4'h0;
  logic [3:0]  extAddrHigh = 4'h0;
  logic [3:0]  portBPeripheralOut;
  integer      miscompares = 0;
  integer      comparisons = 0;
  integer      seed = 32'h4ce9;
  logic [31:0] pudM = 32'h0;
  logic [31:0] cosM = 32'h0;
  logic [31:0] rd;
  logic [31:0] d;
  int          codes[$] = '{0, 7, 8, 16, 17};

  always #25 clk = ~clk;

  pcs_clock_src board (.clocks(clocks), .factoryTestClocks(factoryTestClocks));

  pcs_pad_ctrl dut (
    .clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .pullups(pullups),
    .clocks(clocks), .factoryTestClocks(factoryTestClocks),
    .clockOutPin(clockOutPin), .clockOutPinOe(clockOutPinOe),
    .portBPeripheralEnable(portBPeripheralEnable), .extAddrHigh(extAddrHigh),
    .portBPeripheralOut(portBPeripheralOut));

  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Address phase held until hready, then data phase until hready again
  task automatic busXfer(logic [31:0] a, logic wr, logic [31:0] wd);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr  <= a;
    hwrite <= wr;
    hsize  <= sz;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= HTRANS_IDLE;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : busXfer

  task automatic wr(logic [31:0] a, logic [31:0] wd);
    busXfer(a, 1'b1, wd);
    if (a == PUD) pudM = wd & 32'(PULLUP_DISABLE_MASK);
    if (a == COS) cosM = wd & 32'(CLOCK_OUT_SELECT_MASK);
  endtask : wr

  task automatic chkRd(logic [31:0] a, logic [31:0] exp);
    busXfer(a, 1'b0, 32'h0);
    chk("readback", exp, rd);
  endtask : chkRd

  // New random port B inputs, then compare every pad output mid-cycle, the clock-out pin only while it is driven
  task automatic checkPins();
    logic       co;
    logic [3:0] ck;
    logic [3:0] pb;
    @(posedge clk);
    portBPeripheralEnable <= 4'($random(seed));
    extAddrHigh           <= 4'($random(seed));
    @(negedge clk);
    chk("pullups", 32'({pudM[14:7], pudM[5], pudM[3]}), 32'(pullups));
    case (5'(cosM))
      SRC_OSCILLATOR:  co = clocks.oscillatorOutput;
      SRC_PLL:         co = clocks.pllOutputClock;
      SRC_CONVERTER_A: co = clocks.converterAClock;
      SRC_CONVERTER_B: co = clocks.converterBClock;
      default:         co = clocks.systemClock;
    endcase
    if (!cosM[5]) chk("clockOut", 32'(co), 32'(clockOutPin));
    chk("clockOutOe", 32'(!cosM[5]), 32'(clockOutPinOe));
    ck = {clocks.masterOscillatorClock, clocks.secondarySystemClock,
          clocks.systemClock, clocks.prescalerReferenceClock};
    pb = portBPeripheralEnable & ((cosM[9:6] & ck) | (~cosM[9:6] & extAddrHigh));
    chk("portB", 32'(pb), 32'(portBPeripheralOut));
  endtask : checkPins

  task automatic end_sim();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_sim

  initial begin
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    chkRd(PUD, 32'h0);
    chkRd(COS, 32'h0);
    checkPins();
    chk("hresp", 32'h0, 32'(hresp));
    chk("hreadyout", 32'h1, 32'(hreadyout));
    $display("test reset done");
    for (int i = 0; i < 10; i++) begin
      d = (i == 0) ? 32'hFFFFFFFF : (i == 1) ? 32'h00000200 : $random(seed);
      wr(PUD, d);
      chkRd(PUD, pudM);
      checkPins();
    end
    wr(32'h24, 32'hFFFFFFFF);
    chkRd(32'h24, 32'h0);
    chkRd(PUD, pudM);
    sz = 3'h1;
    busXfer(PUD, 1'b1, ~pudM);
    sz = 3'h2;
    chkRd(PUD, pudM);
    $display("test pullups done");
    // Factory test codes are left out on purpose
    foreach (codes[i]) for (int t = 0; t < 2; t++) begin
      d = $random(seed);
      d[5:0] = {t[0], codes[i][4:0]};
      wr(COS, d);
      chkRd(COS, cosM);
      repeat (4) checkPins();
    end
    $display("test clock out done");
    @(posedge clk);
    reset <= 1'b1;
    @(posedge clk);
    reset <= 1'b0;
    pudM = 32'h0;
    cosM = 32'h0;
    chkRd(PUD, 32'h0);
    chkRd(COS, 32'h0);
    checkPins();
    $display("test second reset done");
    end_sim();
  end

  // Whole run needs well under a thousand cycles
  initial begin
    repeat (3000) @(posedge clk);
    miscompares++;
    end_sim();
  end
endmodule : pcs_pad_ctrl_bench
